// *** design/adc_seq_pkg.sv ***
package adc_seq_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_NEG_SEL    = 8'hBA;
    localparam logic [7:0] ADDR_CONFIG     = 8'hBC;
    localparam logic [7:0] ADDR_RESULT_LO  = 8'hBD;
    localparam logic [7:0] ADDR_RESULT_HI  = 8'hBE;
    localparam logic [7:0] ADDR_UPPER_LO   = 8'hC3;
    localparam logic [7:0] ADDR_UPPER_HI   = 8'hC4;
    localparam logic [7:0] ADDR_LOWER_LO   = 8'hC5;
    localparam logic [7:0] ADDR_LOWER_HI   = 8'hC6;
    localparam logic [7:0] ADDR_CONTROL    = 8'hE8;

    // Reset values
    localparam logic [7:0] RST_CONFIG      = 8'hF8;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [4:0] RST_NEG_SEL     = 5'h00;

    // Control register bit positions
    localparam int CTL_ENABLE  = 7;
    localparam int CTL_TRACK   = 6;
    localparam int CTL_DONE    = 5;
    localparam int CTL_BUSY    = 4;
    localparam int CTL_WINDOW  = 3;
    localparam int CTL_SRC_HI  = 2;

    // Config register fields and negative input select width
    localparam int CFG_DIV_HI  = 7;
    localparam int CFG_DIV_LO  = 3;
    localparam int CFG_LJST    = 2;
    localparam int NEG_SEL_HI  = 4;

    // Negative input code that selects ground
    localparam logic [4:0] NEG_GROUND = 5'h1F;

    // Start source codes
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_TIMER0   = 3'h1;
    localparam logic [2:0] SRC_TIMER2   = 3'h2;
    localparam logic [2:0] SRC_TIMER1   = 3'h3;
    localparam logic [2:0] SRC_STROBE   = 3'h4;
    localparam logic [2:0] SRC_TIMER3   = 3'h5;

    // Sequence lengths in SAR clocks
    localparam logic [3:0] TRACK_SAR_CLKS = 4'h3;
    localparam logic [3:0] CONV_SAR_CLKS  = 4'hA;

    // Result widths
    localparam int RES_W  = 10;
    localparam int WORD_W = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV  = 3'b100
    } seq_state_e;

    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

    // Start trigger inputs
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic timer2_ovf;
        logic timer3_ovf;
    } timer_trig_s;

endpackage : adc_seq_pkg

// *** design/sar_clock_divider.sv ***
`timescale 1ns/1ps
// Emits one system clock pulse per SAR clock period while running.
module sar_clock_divider (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [4:0] divider,
    output logic            sar_tick
);

    logic [4:0] cnt_r;

    // Counter restarts when idle so each sequence starts on a full period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
        end else if (!run || cnt_r == divider) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    assign sar_tick = run && (cnt_r == divider);

endmodule : sar_clock_divider

// *** design/window_compare.sv ***
`timescale 1ns/1ps
// Compares one formatted result word against the two limit words.
module window_compare (
    input  wire logic [15:0] word,
    input  wire logic [15:0] upper_limit,
    input  wire logic [15:0] lower_limit,
    input  wire logic        is_signed,
    output logic             match
);

    logic above_upper;
    logic below_lower;
    logic lower_gt_upper;

    // Signed compare on differential data, unsigned otherwise
    always_comb begin
        if (is_signed) begin
            above_upper    = $signed(word) > $signed(upper_limit);
            below_lower    = $signed(word) < $signed(lower_limit);
            lower_gt_upper = $signed(lower_limit) > $signed(upper_limit);
        end else begin
            above_upper    = word > upper_limit;
            below_lower    = word < lower_limit;
            lower_gt_upper = lower_limit > upper_limit;
        end
        // Inside window when lower exceeds upper, outside otherwise
        if (lower_gt_upper) begin
            match = above_upper && below_lower;
        end else begin
            match = above_upper || below_lower;
        end
    end

endmodule : window_compare

// *** design/adc_sequencer_window_detect.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - SAR clock period is divider field plus one
// - Right justify: high byte sign-extends bit one
// - Left justify: top eight high, two low
// - Enable clear holds converter in shutdown
// - Normal mode tracks except while converting
// - Low-power: track three SAR clocks, then convert
// - Strobe low-power: track while low, convert rising
// - Three-bit field selects the start source
// - Busy write starts only with software source
// - Done flag sets as busy falls
// - Done flag stays set until software clears
// - Window flag sticky until software clears
// - Every result compared against both limits
// - Lower above upper means inside match
// - Upper above lower means outside match
// - Single-ended comparisons are unsigned
// - Differential comparisons are signed
// - Lower limit in two byte registers, reset zero
// - Config bits one and zero read zero
// - Ground negative input means single-ended
// - Conversion takes ten SAR clocks after tracking
module adc_sequencer_window_detect (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire adc_seq_pkg::sfr_req_s    sfr_req,
    input  wire adc_seq_pkg::timer_trig_s timer_trig,
    input  wire logic                     external_convert_strobe,
    input  wire logic [9:0]               sar_data_in,
    output logic [7:0]                    sfr_rdata_r,
    output logic                          converter_on_r,
    output logic                          track_en_r,
    output logic                          convert_active_r,
    output logic                          sar_conversion_clock_r
);

    // Software-visible state
    logic                    converter_enable_r;
    logic                    track_mode_select_r;
    logic                    conversion_done_flag_r;
    logic                    window_match_flag_r;
    logic [2:0]              start_source_select_r;
    logic [4:0]              sar_clock_divider_r;
    logic                    left_justify_select_r;
    logic [4:0]              negative_input_select_r;
    logic [7:0]              result_high_byte_r;
    logic [7:0]              result_low_byte_r;
    logic [7:0]              window_upper_bound_high_r;
    logic [7:0]              window_upper_bound_low_r;
    logic [7:0]              window_lower_bound_high_r;
    logic [7:0]              window_lower_bound_low_r;

    // Sequencer state
    adc_seq_pkg::seq_state_e state_r;
    adc_seq_pkg::seq_state_e state_nxt;
    logic [3:0]              sar_cnt_r;
    logic                    strobe_prev_r;

    logic                    sar_tick;
    logic                    strobe_rise;
    logic                    wr_ctl;
    logic                    busy_write;
    logic                    start_trig;
    logic                    track_done;
    logic                    conv_end;
    logic                    differential;
    logic [15:0]             new_word;
    logic                    new_match;

    // Select the start pulse for a source code; reserved codes never fire
    function automatic logic pick_trigger(
        input logic [2:0]               src,
        input logic                     sw,
        input adc_seq_pkg::timer_trig_s t,
        input logic                     rise
    );
        logic hit;
        hit = 1'b0;
        case (src)
            adc_seq_pkg::SRC_SOFTWARE: hit = sw;
            adc_seq_pkg::SRC_TIMER0:   hit = t.timer0_ovf;
            adc_seq_pkg::SRC_TIMER2:   hit = t.timer2_ovf;
            adc_seq_pkg::SRC_TIMER1:   hit = t.timer1_ovf;
            adc_seq_pkg::SRC_STROBE:   hit = rise;
            adc_seq_pkg::SRC_TIMER3:   hit = t.timer3_ovf;
            default:                   hit = 1'b0;
        endcase
        return hit;
    endfunction : pick_trigger

    // Arrange a raw result into the sixteen-bit register word
    function automatic logic [15:0] format_result(
        input logic [9:0] raw,
        input logic       left
    );
        logic [15:0] w;
        w = 16'h0000;
        if (left) begin
            w = {raw, 6'h00};
        end else begin
            w = {{6{raw[9]}}, raw};
        end
        return w;
    endfunction : format_result

    sar_clock_divider u_div (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (state_r != adc_seq_pkg::ST_IDLE),
        .divider (sar_clock_divider_r),
        .sar_tick(sar_tick)
    );

    // Ground on the negative input means single-ended, unsigned data
    assign differential =
        negative_input_select_r != adc_seq_pkg::NEG_GROUND;
    assign new_word = format_result(sar_data_in, left_justify_select_r);

    window_compare u_win (
        .word       (new_word),
        .upper_limit({window_upper_bound_high_r, window_upper_bound_low_r}),
        .lower_limit({window_lower_bound_high_r, window_lower_bound_low_r}),
        .is_signed  (differential),
        .match      (new_match)
    );

    // Trigger decode; inputs are synchronous so one flop finds the edge
    assign wr_ctl      = sfr_req.wr && sfr_req.addr == adc_seq_pkg::ADDR_CONTROL;
    assign busy_write  = wr_ctl && sfr_req.wdata[adc_seq_pkg::CTL_BUSY];
    assign strobe_rise = external_convert_strobe && !strobe_prev_r;
    assign start_trig  = converter_enable_r && pick_trigger(
        start_source_select_r, busy_write, timer_trig, strobe_rise);
    assign track_done  = sar_tick
                         && sar_cnt_r == adc_seq_pkg::TRACK_SAR_CLKS - 4'h1;
    assign conv_end    = state_r == adc_seq_pkg::ST_CONV && sar_tick
                         && sar_cnt_r == adc_seq_pkg::CONV_SAR_CLKS - 4'h1;

    // Next state; triggers only matter from idle, so a busy block ignores them
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adc_seq_pkg::ST_IDLE: begin
                if (start_trig) begin
                    if (track_mode_select_r
                        && start_source_select_r != adc_seq_pkg::SRC_STROBE) begin
                        state_nxt = adc_seq_pkg::ST_TRACK;
                    end else begin
                        state_nxt = adc_seq_pkg::ST_CONV;
                    end
                end
            end
            adc_seq_pkg::ST_TRACK: begin
                if (track_done) begin
                    state_nxt = adc_seq_pkg::ST_CONV;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (conv_end) begin
                    state_nxt = adc_seq_pkg::ST_IDLE;
                end
            end
            default: state_nxt = adc_seq_pkg::ST_IDLE;
        endcase
        if (!converter_enable_r) begin
            state_nxt = adc_seq_pkg::ST_IDLE;
        end
    end

    // State register and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r       <= adc_seq_pkg::ST_IDLE;
            strobe_prev_r <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            strobe_prev_r <= external_convert_strobe;
        end
    end

    // SAR clock count within the current phase, cleared on every change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_cnt_r <= 4'h0;
        end else if (state_nxt != state_r) begin
            sar_cnt_r <= 4'h0;
        end else if (sar_tick) begin
            sar_cnt_r <= sar_cnt_r + 4'h1;
        end
    end

    // Control register fields that software simply stores
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_enable_r    <= 1'b0;
            track_mode_select_r   <= 1'b0;
            start_source_select_r <= 3'h0;
        end else if (wr_ctl) begin
            converter_enable_r    <= sfr_req.wdata[adc_seq_pkg::CTL_ENABLE];
            track_mode_select_r   <= sfr_req.wdata[adc_seq_pkg::CTL_TRACK];
            start_source_select_r <=
                sfr_req.wdata[adc_seq_pkg::CTL_SRC_HI:0];
        end
    end

    // Done flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag_r <= 1'b0;
        end else if (conv_end) begin
            conversion_done_flag_r <= 1'b1;
        end else if (wr_ctl) begin
            conversion_done_flag_r <=
                sfr_req.wdata[adc_seq_pkg::CTL_DONE];
        end
    end

    // Window flag: set on a matching result, cleared only by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_match_flag_r <= 1'b0;
        end else if (conv_end && new_match) begin
            window_match_flag_r <= 1'b1;
        end else if (wr_ctl) begin
            window_match_flag_r <=
                sfr_req.wdata[adc_seq_pkg::CTL_WINDOW];
        end
    end

    // Result bytes load on the edge where busy falls, together with the done flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_high_byte_r <= adc_seq_pkg::RST_ZERO;
            result_low_byte_r  <= adc_seq_pkg::RST_ZERO;
        end else if (conv_end) begin
            result_high_byte_r <= new_word[15:8];
            result_low_byte_r  <= new_word[7:0];
        end else if (sfr_req.wr) begin
            if (sfr_req.addr == adc_seq_pkg::ADDR_RESULT_HI) begin
                result_high_byte_r <= sfr_req.wdata;
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_RESULT_LO) begin
                result_low_byte_r <= sfr_req.wdata;
            end
        end
    end

    // Configuration, input select and limit registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_clock_divider_r <=
                adc_seq_pkg::RST_CONFIG[adc_seq_pkg::CFG_DIV_HI:
                                        adc_seq_pkg::CFG_DIV_LO];
            left_justify_select_r <=
                adc_seq_pkg::RST_CONFIG[adc_seq_pkg::CFG_LJST];
            negative_input_select_r   <= adc_seq_pkg::RST_NEG_SEL;
            window_upper_bound_high_r <= adc_seq_pkg::RST_ZERO;
            window_upper_bound_low_r  <= adc_seq_pkg::RST_ZERO;
            window_lower_bound_high_r <= adc_seq_pkg::RST_ZERO;
            window_lower_bound_low_r  <= adc_seq_pkg::RST_ZERO;
        end else if (sfr_req.wr) begin
            if (sfr_req.addr == adc_seq_pkg::ADDR_CONFIG) begin
                sar_clock_divider_r <=
                    sfr_req.wdata[adc_seq_pkg::CFG_DIV_HI:
                                  adc_seq_pkg::CFG_DIV_LO];
                left_justify_select_r <=
                    sfr_req.wdata[adc_seq_pkg::CFG_LJST];
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_NEG_SEL) begin
                negative_input_select_r <=
                    sfr_req.wdata[adc_seq_pkg::NEG_SEL_HI:0];
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_UPPER_HI) begin
                window_upper_bound_high_r <= sfr_req.wdata;
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_UPPER_LO) begin
                window_upper_bound_low_r <= sfr_req.wdata;
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_LOWER_HI) begin
                window_lower_bound_high_r <= sfr_req.wdata;
            end else if (sfr_req.addr == adc_seq_pkg::ADDR_LOWER_LO) begin
                window_lower_bound_low_r <= sfr_req.wdata;
            end
        end
    end

    // Read data registered one cycle after the read strobe; unmapped reads 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_r <= adc_seq_pkg::RST_ZERO;
        end else if (!sfr_req.rd) begin
            sfr_rdata_r <= adc_seq_pkg::RST_ZERO;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_CONTROL) begin
            sfr_rdata_r <= {converter_enable_r, track_mode_select_r,
                            conversion_done_flag_r,
                            state_r != adc_seq_pkg::ST_IDLE,
                            window_match_flag_r, start_source_select_r};
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_CONFIG) begin
            sfr_rdata_r <= {sar_clock_divider_r, left_justify_select_r,
                            2'b00};
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_NEG_SEL) begin
            sfr_rdata_r <= {3'h0, negative_input_select_r};
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_RESULT_HI) begin
            sfr_rdata_r <= result_high_byte_r;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_RESULT_LO) begin
            sfr_rdata_r <= result_low_byte_r;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_UPPER_HI) begin
            sfr_rdata_r <= window_upper_bound_high_r;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_UPPER_LO) begin
            sfr_rdata_r <= window_upper_bound_low_r;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_LOWER_HI) begin
            sfr_rdata_r <= window_lower_bound_high_r;
        end else if (sfr_req.addr == adc_seq_pkg::ADDR_LOWER_LO) begin
            sfr_rdata_r <= window_lower_bound_low_r;
        end else begin
            sfr_rdata_r <= adc_seq_pkg::RST_ZERO;
        end
    end

    // Analog control levels; track and convert are registered from the next state so they
    // line up with the state register, while on and tick lag their sources by one clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_on_r         <= 1'b0;
            track_en_r             <= 1'b0;
            convert_active_r       <= 1'b0;
            sar_conversion_clock_r <= 1'b0;
        end else begin
            converter_on_r   <= converter_enable_r;
            convert_active_r <= state_nxt == adc_seq_pkg::ST_CONV;
            sar_conversion_clock_r <= sar_tick;
            if (!converter_enable_r) begin
                track_en_r <= 1'b0;
            end else if (!track_mode_select_r) begin
                track_en_r <= state_nxt != adc_seq_pkg::ST_CONV;
            end else if (start_source_select_r
                         == adc_seq_pkg::SRC_STROBE) begin
                track_en_r <= state_nxt == adc_seq_pkg::ST_IDLE
                              && !external_convert_strobe;
            end else begin
                track_en_r <= state_nxt == adc_seq_pkg::ST_TRACK;
            end
        end
    end

endmodule : adc_sequencer_window_detect

// *** test/sar_analog_model.sv ***
`timescale 1ns/1ps
// Analog side stand-in: drives the sample level only while converting
module sar_analog_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       convert_active_r,
    input  wire logic [9:0] level,
    output logic [9:0]      sar_data_in
);
    // Toggles outside conversions so a sample taken late shows up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sar_data_in <= 10'h000;
        else sar_data_in <= convert_active_r ? level : ~sar_data_in;
    end
endmodule : sar_analog_model

// *** test/adc_seq_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks; the block has a single clock domain
module adc_seq_assertions (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire adc_seq_pkg::sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata_r,
    input wire logic                  converter_on_r,
    input wire logic                  track_en_r,
    input wire logic                  convert_active_r,
    input wire logic                  sar_conversion_clock_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] conv_n_r;
    logic [3:0] trk_n_r;
    logic       cnv_d_r;
    logic       trk_d_r;
    // Tick output lags the phase by one clock, so phases are delayed too
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnv_d_r <= 1'b0;
        else cnv_d_r <= convert_active_r;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) trk_d_r <= 1'b0;
        else trk_d_r <= track_en_r;
    end
    // SAR ticks per phase; saturate so a stuck phase cannot wrap to 10
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) conv_n_r <= 4'h0;
        else if (!cnv_d_r) conv_n_r <= 4'h0;
        else if (sar_conversion_clock_r && conv_n_r != 4'hF)
            conv_n_r <= conv_n_r + 4'h1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) trk_n_r <= 4'h0;
        else if (!trk_d_r) trk_n_r <= 4'h0;
        else if (sar_conversion_clock_r && trk_n_r != 4'hF)
            trk_n_r <= trk_n_r + 4'h1;
    end
    sequence ctl_wr;
        sfr_req.wr && sfr_req.addr == adc_seq_pkg::ADDR_CONTROL;
    endsequence
    sequence sw_go;
        ctl_wr ##0 sfr_req.wdata == 8'h90 && !convert_active_r;
    endsequence
    cfg_pad_zero_a: assert property (
        sfr_req.rd && sfr_req.addr == adc_seq_pkg::ADDR_CONFIG
        |=> sfr_rdata_r[1:0] == 2'b00) else $error("config pad bits set");
    sw_start_a: assert property (sw_go |=> convert_active_r &&
        !track_en_r) else $error("software start missed");
    zero_write_a: assert property (
        ctl_wr ##0 sfr_req.wdata[4:0] == 5'h00 && !convert_active_r
        |=> !convert_active_r) else $error("start without busy write");
    other_src_a: assert property (
        ctl_wr ##0 sfr_req.wdata[4] && sfr_req.wdata[2:0] != 3'h0
        && !convert_active_r |=> !convert_active_r)
        else $error("busy write started foreign source");
    shutdown_a: assert property (!converter_on_r [*2] |->
        !convert_active_r && !track_en_r) else $error("active while off");
    conv_track_a: assert property (convert_active_r |->
        !track_en_r) else $error("tracking during conversion");
    conv_ten_a: assert property (
        $fell(convert_active_r) && converter_on_r |=> conv_n_r == 4'hA)
        else $error("conversion not ten SAR clocks");
    lp_track_a: assert property (
        $rose(convert_active_r) && trk_n_r != 4'h0 |=> trk_n_r == 4'h3)
        else $error("tracking not three SAR clocks");
endmodule : adc_seq_assertions

// *** test/adc_sequencer_window_detect_bench.sv ***
`timescale 1ns/1ps
module adc_sequencer_window_detect_bench;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    adc_seq_pkg::sfr_req_s    req;
    adc_seq_pkg::timer_trig_s tt;
    logic                     stb;
    logic [9:0]               lvl;
    logic [9:0]               sdat;
    logic [7:0]               rdat;
    logic                     on_r;
    logic                     trk_r;
    logic                     cnv_r;
    logic                     tick_r;
    int                       n_errors = 0;
    int                       cmp_count = 0;
    always #5 clk = ~clk;
    adc_sequencer_window_detect adc_sequencer_window_detect_i (
        .clk(clk), .rst_n(rst_n), .sfr_req(req), .timer_trig(tt),
        .external_convert_strobe(stb), .sar_data_in(sdat),
        .sfr_rdata_r(rdat), .converter_on_r(on_r), .track_en_r(trk_r),
        .convert_active_r(cnv_r), .sar_conversion_clock_r(tick_r));
    sar_analog_model sar_analog_model_i (.clk(clk), .rst_n(rst_n),
        .convert_active_r(cnv_r), .level(lvl), .sar_data_in(sdat));
    task chk(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task print_verdict;
        $display("Checks %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Bus cycles: strobes live one clock, changed on falling edges
    task wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk); req.addr = a; req.wdata = d; req.wr = 1'b1;
        @(negedge clk); req.wr = 1'b0;
    endtask : wr
    task rd(logic [7:0] a, output logic [7:0] q);
        @(negedge clk); req.addr = a; req.rd = 1'b1;
        @(negedge clk); req.rd = 1'b0; q = rdat;
    endtask : rd
    task pulse(logic [3:0] v);
        @(negedge clk); tt = v;
        @(negedge clk); tt = 4'h0;
    endtask : pulse
    // Counts falling edges until a started conversion ends
    task run(output int n);
        bit s;
        n = 0; s = 0;
        for (int i = 0; i < 600; i++) begin
            @(negedge clk);
            if (cnv_r === 1'b1) s = 1;
            else if (s) break;
            n++;
        end
    endtask : run
    task lim(logic [7:0] ns, logic [15:0] up, logic [15:0] dn);
        wr(8'hBA, ns); wr(8'hC4, up[15:8]); wr(8'hC3, up[7:0]);
        wr(8'hC6, dn[15:8]); wr(8'hC5, dn[7:0]);
    endtask : lim
    task conv(logic [7:0] cfg, logic [9:0] v, logic [7:0] hi, lo, logic w);
        int n;
        logic [7:0] q;
        lvl = v; wr(8'hBC, cfg); wr(8'hE8, 8'h80); rd(8'hE8, q);
        chk("flags_clear", q[5:3], 3'h0);
        wr(8'hE8, 8'h90); run(n);
        chk("conv_len", n, 10 * (cfg[7:3] + 1) - 1);
        repeat (20) @(negedge clk);
        chk("tracking", trk_r, 1'b1);
        rd(8'hE8, q);
        chk("done_busy", q[5:4], 2'b10);
        chk("window", q[3], w);
        rd(8'hBE, q); chk("res_hi", q, hi);
        rd(8'hBD, q); chk("res_lo", q, lo);
    endtask : conv
    task t_regs;
        logic [7:0] q;
        rd(8'hBC, q); chk("cfg_rst", q, 8'hF8);
        rd(8'hC5, q); chk("lt_lo_rst", q, 8'h00);
        rd(8'hC6, q); chk("lt_hi_rst", q, 8'h00);
        wr(8'hBC, 8'hFF); rd(8'hBC, q); chk("cfg_pad", q, 8'hFC);
        wr(8'hC5, 8'hA5); wr(8'hC6, 8'h5A);
        rd(8'hC5, q); chk("lt_lo", q, 8'hA5);
        rd(8'hC6, q); chk("lt_hi", q, 8'h5A);
        rd(8'h00, q); chk("unmapped", q, 8'h00);
    endtask : t_regs
    task t_window;
        lim(8'h1F, 16'h0040, 16'h0080);
        conv(8'h00, 10'h2C5, 8'hFE, 8'hC5, 1'b0);
        conv(8'h04, 10'h2C5, 8'hB1, 8'h40, 1'b0);
        conv(8'h08, 10'h050, 8'h00, 8'h50, 1'b1);
        conv(8'h00, 10'h040, 8'h00, 8'h40, 1'b0);
        lim(8'h1F, 16'h0080, 16'h0040);
        conv(8'h00, 10'h030, 8'h00, 8'h30, 1'b1);
        conv(8'h00, 10'h080, 8'h00, 8'h80, 1'b0);
        lim(8'h00, 16'hFFFF, 16'h0040);
        conv(8'h00, 10'h3FE, 8'hFF, 8'hFE, 1'b0);
        conv(8'h00, 10'h000, 8'h00, 8'h00, 1'b1);
    endtask : t_window
    task t_timers;
        int n;
        logic [2:0] s [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
        logic [3:0] p [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
        for (int i = 0; i < 4; i++) begin
            wr(8'hE8, {5'b11000, s[i]}); pulse(p[i]); run(n);
            chk("lp_len", n, 12);
        end
        wr(8'hE8, 8'h80); wr(8'hE8, 8'h90); wr(8'hE8, 8'h90); run(n);
        chk("busy_ignore", n, 10 - 3);
        wr(8'hE8, 8'hC6); pulse(4'hF); repeat (3) @(negedge clk);
        chk("reserved", {trk_r, cnv_r}, 2'b00);
        wr(8'hE8, 8'h91); repeat (3) @(negedge clk);
        chk("foreign_src", cnv_r, 1'b0);
        wr(8'hE8, 8'h10); repeat (3) @(negedge clk);
        chk("shutdown", {on_r, trk_r, cnv_r}, 3'b000);
    endtask : t_timers
    task t_strobe;
        int n;
        logic [7:0] q;
        wr(8'hE8, 8'hC4); repeat (2) @(negedge clk);
        chk("strobe_high", trk_r, 1'b0);
        stb = 1'b0; repeat (3) @(negedge clk);
        chk("strobe_low", {trk_r, cnv_r}, 2'b10);
        stb = 1'b1; repeat (3) @(negedge clk);
        chk("strobe_rise", {trk_r, cnv_r}, 2'b01);
        run(n); rd(8'hE8, q);
        chk("strobe_done", q[5], 1'b1);
    endtask : t_strobe
    // Whole run is several hundred cycles; this bound only cuts a hang
    initial begin
        #300000;
        n_errors++;
        print_verdict();
    end
    initial begin
        req = '0; tt = '0; stb = 1'b1; lvl = 10'h000;
        repeat (4) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_regs(); t_window(); t_timers(); t_strobe();
        print_verdict();
    end
endmodule : adc_sequencer_window_detect_bench
bind adc_sequencer_window_detect adc_seq_assertions adc_seq_assertions_i (
    .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata_r(sfr_rdata_r),
    .converter_on_r(converter_on_r), .track_en_r(track_en_r),
    .convert_active_r(convert_active_r),
    .sar_conversion_clock_r(sar_conversion_clock_r));
